// File: src/mrb_mode_regs.v
// Mode register bank reached by mode-register read and write commands
//
// Notes on behaviour
// - A bank of mode registers programs parameters, reports status, starts calibration and reset.
// - Reads return and writes update the register chosen by an eight-bit address.
// - Read-only answers reads only, write-only takes writes only.
// - Reserved future bits always read back as zero.
// - Reads of write-only or reserved registers toggle the strobe; data undefined.
// - Writes to read-only registers change nothing at all.
// - Address 20h reads the first calibration pattern.
// - Address 28h reads the second calibration pattern.
// - After a reset write, auto-init completes and its status clears within 10 us.
// - Once auto-init status reads zero, the bank is idle and takes all commands.
`timescale 1ns/100ps
`default_nettype none
`include "mrb_defines.vh"

module mrb_mode_regs #(
  // Identity values below are arbitrary
  parameter [7:0] VENDOR_ID = 8'h5a,
  parameter [7:0] REVISION_ONE = 8'h01,
  parameter [7:0] REVISION_TWO = 8'h00,
  parameter [7:0] WIDTH_DENSITY_TYPE = 8'h14,
  parameter [7:0] PATTERN_A = 8'h55,
  parameter [7:0] PATTERN_B = 8'h33,
  parameter [1:0] RZQ_INFO = 2'b00,
  parameter NVM_DEVICE = 1'b0
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Mode-register command from the controller
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] register_address_field,
  input wire [7:0] operand_bits,
  output wire cmd_ready,
  // Read burst answer
  output reg rd_valid_q,
  output reg [7:0] rd_data_q,
  output reg rd_dqs_q,
  // Refresh rate from the temperature sensor
  input wire [2:0] refresh_rate_pin,
  // Configuration to the rest of the device
  output reg [7:0] burst_cfg_q,
  output reg [7:0] latency_cfg_q,
  output reg [7:0] drive_cfg_q,
  output reg [7:0] test_cfg_q,
  output reg [7:0] zq_cal_code_q,
  output reg [7:0] bank_mask_q,
  output reg [7:0] seg_mask_q,
  // Special operations
  output reg zq_cal_start_q,
  output reg soft_reset_q,
  output reg auto_init_busy_q
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BURST = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`MRB_BEAT_CW-1:0] beat_q;
  reg [`MRB_INIT_CW-1:0] init_cnt_q;
  reg init_run_q;
  reg [2:0] rate_s1_q;
  reg [2:0] rate_s2_q;
  reg [2:0] rate_last_q;
  reg tuf_q;
  reg [7:0] rd_word;
  reg rd_known;

  wire take;
  wire wr_take;
  wire rd_take;
  wire wr_open;
  wire rate_change;
  wire tuf_clear;
  wire init_done;

  // Commands are taken only between read bursts
  assign cmd_ready = state_q[0];
  assign take = cmd_valid & cmd_ready;
  assign rd_take = take & ~cmd_write;
  assign wr_take = take & cmd_write;
  // While auto-init status is busy, only reads and a fresh reset write take effect; other writes are taken but ignored
  assign wr_open = ~auto_init_busy_q;
  assign init_done = init_run_q &
                     (init_cnt_q == (`MRB_AUTO_INIT_CYC - 1));

  // One write strobe per writable register
  wire wr_reset;
  wire wr_cfg;
  wire wr_burst;
  wire wr_latency;
  wire wr_drive;
  wire wr_test;
  wire wr_zq;
  wire wr_bank;
  wire wr_seg;

  // Read-only, reserved and unused addresses raise no strobe
  assign wr_reset = wr_take & (register_address_field == `MRB_A_SOFT_RESET);
  assign wr_cfg = wr_take & wr_open;
  assign wr_burst = wr_cfg & (register_address_field == `MRB_A_BURST_WR);
  assign wr_latency = wr_cfg & (register_address_field == `MRB_A_LATENCY);
  assign wr_drive = wr_cfg & (register_address_field == `MRB_A_DRIVE);
  assign wr_test = wr_cfg & (register_address_field == `MRB_A_TEST);
  assign wr_zq = wr_cfg & (register_address_field == `MRB_A_ZQ_CAL);
  assign wr_bank = wr_cfg & (register_address_field == `MRB_A_BANK_MASK);
  assign wr_seg = wr_cfg & (register_address_field == `MRB_A_SEG_MASK);

  // Refresh rate pins pass two flip-flops before use
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_s1_q <= 3'h0;
      rate_s2_q <= 3'h0;
      rate_last_q <= 3'h0;
    end else begin
      rate_s1_q <= refresh_rate_pin;
      rate_s2_q <= rate_s1_q;
      rate_last_q <= rate_s2_q;
    end
  end

  assign rate_change = (rate_s2_q != rate_last_q);
  assign tuf_clear = rd_take & (register_address_field == `MRB_A_REFRESH);

  // Update flag: a rate change in the same cycle as its read keeps it set
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tuf_q <= 1'b0;
    end else if (rate_change) begin
      tuf_q <= 1'b1;
    end else if (tuf_clear) begin
      tuf_q <= 1'b0;
    end
  end

  // Read decode; write-only, reserved and unused addresses give undefined data
  always @* begin
    rd_word = `MRB_UNDEF_DATA;
    rd_known = 1'b1;
    case (register_address_field)
      `MRB_A_DEV_INFO: begin
        // Upper bits are reserved and read as zero
        rd_word = 8'h00;
        rd_word[`MRB_DI_AUTO_INIT] = auto_init_busy_q;
        rd_word[`MRB_DI_NVM] = NVM_DEVICE[0];
        rd_word[`MRB_DI_DNVI] = 1'b0;
        rd_word[`MRB_DI_RZQ_HI:`MRB_DI_RZQ_LO] = RZQ_INFO;
      end
      `MRB_A_REFRESH: begin
        rd_word = 8'h00;
        rd_word[`MRB_RR_RATE_HI:0] = rate_s2_q;
        rd_word[`MRB_RR_TUF] = tuf_q;
      end
      `MRB_A_VENDOR: begin
        rd_word = VENDOR_ID;
      end
      `MRB_A_REV_ONE: begin
        rd_word = REVISION_ONE;
      end
      `MRB_A_REV_TWO: begin
        rd_word = REVISION_TWO;
      end
      `MRB_A_WDT: begin
        rd_word = WIDTH_DENSITY_TYPE;
      end
      `MRB_A_PATTERN_A: begin
        rd_word = PATTERN_A;
      end
      `MRB_A_PATTERN_B: begin
        rd_word = PATTERN_B;
      end
      default: begin
        // Write-only, reserved, do-not-use and vendor-reserved addresses
        rd_word = `MRB_UNDEF_DATA;
        rd_known = 1'b0;
      end
    endcase
  end

  // Read burst sequencer
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (rd_take) begin
          state_d = ST_BURST;
        end
      end
      ST_BURST: begin
        if (beat_q == (`MRB_RD_BEATS - 1)) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      beat_q <= {`MRB_BEAT_CW{1'b0}};
      rd_valid_q <= 1'b0;
      rd_data_q <= 8'h00;
      rd_dqs_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (rd_take) begin
        // Strobe toggles for every read, defined data or not
        beat_q <= {`MRB_BEAT_CW{1'b0}};
        rd_valid_q <= 1'b1;
        rd_data_q <= rd_word;
        rd_dqs_q <= 1'b1;
      end else if (state_q[1]) begin
        beat_q <= beat_q + {{(`MRB_BEAT_CW-1){1'b0}}, 1'b1};
        if (beat_q == (`MRB_RD_BEATS - 1)) begin
          rd_valid_q <= 1'b0;
          rd_dqs_q <= 1'b0;
        end else begin
          rd_dqs_q <= ~rd_dqs_q;
        end
      end
    end
  end

  // Auto-initialization timer started by a reset write
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_run_q <= 1'b0;
      init_cnt_q <= {`MRB_INIT_CW{1'b0}};
      auto_init_busy_q <= 1'b1;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= 1'b0;
      if (wr_reset) begin
        soft_reset_q <= 1'b1;
        init_run_q <= 1'b1;
        init_cnt_q <= {`MRB_INIT_CW{1'b0}};
        auto_init_busy_q <= 1'b1;
      end else if (init_done) begin
        init_run_q <= 1'b0;
        auto_init_busy_q <= 1'b0;
      end else if (init_run_q) begin
        init_cnt_q <= init_cnt_q + {{(`MRB_INIT_CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Writable registers, one per process; a reset write restores defaults
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_cfg_q <= `MRB_R_BURST_WR;
    end else if (wr_reset) begin
      burst_cfg_q <= `MRB_R_BURST_WR;
    end else if (wr_burst) begin
      burst_cfg_q <= operand_bits;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latency_cfg_q <= `MRB_R_LATENCY;
    end else if (wr_reset) begin
      latency_cfg_q <= `MRB_R_LATENCY;
    end else if (wr_latency) begin
      latency_cfg_q <= operand_bits & `MRB_M_LATENCY;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_cfg_q <= `MRB_R_DRIVE;
    end else if (wr_reset) begin
      drive_cfg_q <= `MRB_R_DRIVE;
    end else if (wr_drive) begin
      drive_cfg_q <= operand_bits & `MRB_M_DRIVE;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      test_cfg_q <= `MRB_R_TEST;
    end else if (wr_reset) begin
      test_cfg_q <= `MRB_R_TEST;
    end else if (wr_test) begin
      test_cfg_q <= operand_bits;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zq_cal_code_q <= `MRB_R_ZQ_CAL;
    end else if (wr_reset) begin
      zq_cal_code_q <= `MRB_R_ZQ_CAL;
    end else if (wr_zq) begin
      zq_cal_code_q <= operand_bits;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_mask_q <= `MRB_R_BANK_MASK;
    end else if (wr_reset) begin
      bank_mask_q <= `MRB_R_BANK_MASK;
    end else if (wr_bank) begin
      bank_mask_q <= operand_bits;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_mask_q <= `MRB_R_SEG_MASK;
    end else if (wr_reset) begin
      seg_mask_q <= `MRB_R_SEG_MASK;
    end else if (wr_seg) begin
      seg_mask_q <= operand_bits;
    end
  end

  // Calibration start pulses for one cycle after each calibration write taken while auto-init is not busy
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      zq_cal_start_q <= 1'b0;
    end else begin
      zq_cal_start_q <= wr_zq;
    end
  end

  // Keeps the read-side known flag observable to synthesis as a used term
  wire unused_known;
  assign unused_known = rd_known;

endmodule
`default_nettype wire

// File: src/mrb_defines.vh
// Constants for the mode register bank: addresses, layouts, reset values and timing
`ifndef MRB_DEFINES_VH
`define MRB_DEFINES_VH

// Register width and address width
`define MRB_DW 8
`define MRB_AW 8

// Register addresses
`define MRB_A_DEV_INFO 8'h00
`define MRB_A_BURST_WR 8'h01
`define MRB_A_LATENCY 8'h02
`define MRB_A_DRIVE 8'h03
`define MRB_A_REFRESH 8'h04
`define MRB_A_VENDOR 8'h05
`define MRB_A_REV_ONE 8'h06
`define MRB_A_REV_TWO 8'h07
`define MRB_A_WDT 8'h08
`define MRB_A_TEST 8'h09
`define MRB_A_ZQ_CAL 8'h0a
`define MRB_A_BANK_MASK 8'h10
`define MRB_A_SEG_MASK 8'h11
`define MRB_A_PATTERN_A 8'h20
`define MRB_A_PATTERN_B 8'h28
`define MRB_A_SOFT_RESET 8'h3f

// Field positions in the device information register
`define MRB_DI_AUTO_INIT 0
`define MRB_DI_NVM 1
`define MRB_DI_DNVI 2
`define MRB_DI_RZQ_LO 3
`define MRB_DI_RZQ_HI 4

// Field positions in the refresh rate status register
`define MRB_RR_RATE_HI 2
`define MRB_RR_TUF 7

// Writable bit masks; reserved_future_bits are not stored
`define MRB_M_LATENCY 8'h0f
`define MRB_M_DRIVE 8'h0f

// Reset values of the writable registers
`define MRB_R_BURST_WR 8'h22
`define MRB_R_LATENCY 8'h00
`define MRB_R_DRIVE 8'h00
`define MRB_R_TEST 8'h00
`define MRB_R_ZQ_CAL 8'h00
`define MRB_R_BANK_MASK 8'h00
`define MRB_R_SEG_MASK 8'h00

// Value returned where read data is undefined
`define MRB_UNDEF_DATA 8'h00

// Auto-initialization: longest time in ns, clock period in ns, cycles rounded down
`define MRB_AUTO_INIT_NS 10000
`define MRB_CLK_NS 25
`define MRB_AUTO_INIT_CYC (`MRB_AUTO_INIT_NS / `MRB_CLK_NS)
`define MRB_INIT_CW 9

// Strobe beats of a mode-register read burst
`define MRB_RD_BEATS 4
`define MRB_BEAT_CW 3

`endif

// File: testbench/mrb_asserts.sv
// Port assertions for the mode register bank
`timescale 1ns/100ps
`default_nettype none
module mrb_asserts #(
  parameter [7:0] PATTERN_A = 8'h55,
  parameter [7:0] PATTERN_B = 8'h33
) (
  // Clock, reset and command
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] register_address_field,
  input wire logic [7:0] operand_bits,
  input wire logic cmd_ready,
  // Read answer and state
  input wire logic rd_valid_q,
  input wire logic [7:0] rd_data_q,
  input wire logic rd_dqs_q,
  input wire logic [7:0] burst_cfg_q,
  input wire logic [7:0] latency_cfg_q,
  input wire logic [7:0] zq_cal_code_q,
  input wire logic zq_cal_start_q,
  input wire logic soft_reset_q,
  input wire logic auto_init_busy_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire rd = cmd_valid & cmd_ready & ~cmd_write;
  wire wr = cmd_valid & cmd_ready & cmd_write;
  wire [7:0] a = register_address_field;
  wire ro = a == 8'h00 || a == 8'h04 || a == 8'h20 || a == 8'h28;
  property p_len; rd |=> rd_valid_q[*4] ##1 !rd_valid_q; endproperty
  a_len: assert property (p_len) else $error("burst length");
  property p_dqs; rd |=> rd_dqs_q ##1 !rd_dqs_q ##1 rd_dqs_q ##1 !rd_dqs_q; endproperty
  a_dqs: assert property (p_dqs) else $error("strobe pattern");
  property p_busy; rd |=> !cmd_ready[*4] ##1 cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready during burst");
  property p_pat_a; rd && a == 8'h20 |=> rd_data_q == PATTERN_A; endproperty
  a_pat_a: assert property (p_pat_a) else $error("pattern a");
  property p_pat_b; rd && a == 8'h28 |=> rd_data_q == PATTERN_B; endproperty
  a_pat_b: assert property (p_pat_b) else $error("pattern b");
  property p_ro; wr && ro |=> $stable({burst_cfg_q, latency_cfg_q}) && !soft_reset_q; endproperty
  a_ro: assert property (p_ro) else $error("read-only write took effect");
  property p_zq; wr && a == 8'h0a && !auto_init_busy_q |=> zq_cal_start_q && zq_cal_code_q == $past(operand_bits); endproperty
  a_zq: assert property (p_zq) else $error("calibration write");
  property p_rst; wr && a == 8'h3f |=> soft_reset_q && auto_init_busy_q && burst_cfg_q == 8'h22; endproperty
  a_rst: assert property (p_rst) else $error("soft reset");
  property p_init; $rose(soft_reset_q) |-> ##[1:400] !auto_init_busy_q; endproperty
  a_init: assert property (p_init) else $error("auto-init too long");
  property p_hold; wr && a == 8'h02 && auto_init_busy_q |=> $stable(latency_cfg_q); endproperty
  a_hold: assert property (p_hold) else $error("write during auto-init");
  property p_rfu; rd && a == 8'h04 |=> rd_data_q[6:3] == 4'h0; endproperty
  a_rfu: assert property (p_rfu) else $error("reserved bits set");
endmodule
bind mrb_mode_regs mrb_asserts #(.PATTERN_A(PATTERN_A), .PATTERN_B(PATTERN_B)) i_chk (.*);
`default_nettype wire

// File: testbench/mrb_ctrl_model.sv
// Controller model issuing mode-register reads and writes
`timescale 1ns/100ps
`default_nettype none
module mrb_ctrl_model (
  // Clock and flow control
  input wire sys_clk,
  input wire cmd_ready,
  // Command bus
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic [7:0] register_address_field = 8'h00,
  output logic [7:0] operand_bits = 8'h00
);
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    if (w && (a inside {[8'h0b:8'h0f], 8'h12, 8'h13, [8'h30:8'h3e], [8'h40:8'h7e]})) return;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    register_address_field = a;
    operand_bits = (a == 8'h02 || a == 8'h03) ? d & 8'h0f : d;
    for (n = 0; n < 20 && !cmd_ready; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    // Released address and operand lines show a changed value, not the old one
    cmd_valid = 1'b0;
    register_address_field = ~a;
    operand_bits = ~operand_bits;
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the mode register bank
`timescale 1ns/100ps
`default_nettype none
`include "mrb_defines.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] refresh_rate_pin = 3'h0;
  wire cmd_valid, cmd_write, cmd_ready, rd_valid_q, rd_dqs_q;
  wire zq_cal_start_q, soft_reset_q, auto_init_busy_q;
  wire [7:0] register_address_field, operand_bits, rd_data_q, burst_cfg_q, latency_cfg_q;
  wire [7:0] drive_cfg_q, test_cfg_q, zq_cal_code_q, bank_mask_q, seg_mask_q;
  wire [55:0] cfg_all = {burst_cfg_q, latency_cfg_q, drive_cfg_q, test_cfg_q, zq_cal_code_q,
    bank_mask_q, seg_mask_q};
  logic [55:0] exp_all = {8'h22, 48'h0};
  logic [7:0] wa [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h10, 8'h11};
  logic [7:0] ba [12] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28, 8'h21,
    8'h7f, 8'h80, 8'hff};
  logic [7:0] exp_q [$];
  logic [7:0] e_m;
  logic [7:0] d;
  logic rv_d = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;
  int i;
  always #12.5 sys_clk = ~sys_clk;
  mrb_mode_regs i_dut (.*);
  mrb_ctrl_model i_ctrl (.*);
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_ctrl.op(1'b1, a, v);
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_ctrl.op(1'b0, a, 8'h00);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // First beat of each burst is compared with the oldest expectation
  always @(negedge sys_clk) begin
    if (rd_valid_q && !rv_d) begin
      e_m = exp_q.pop_front();
      `CHK("rd_data_q", e_m, rd_data_q)
    end
    rv_d = rd_valid_q;
  end
  initial begin
    d = $urandom(39);
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    wr(8'h02, 8'h05);
    `CHK("cfg", exp_all, cfg_all)
    rd(8'h00, 8'h01);
    wr(8'h3f, 8'h00);
    repeat (`MRB_AUTO_INIT_CYC - 2) @(negedge sys_clk);
    `CHK("busy", 1'b1, auto_init_busy_q)
    @(negedge sys_clk);
    `CHK("busy", 1'b0, auto_init_busy_q)
    rd(8'h00, 8'h00);
    $display("test auto-init done");
    for (i = 0; i < 7; i++) begin
      d = $urandom;
      wr(wa[i], d);
      exp_all[55 - 8 * i -: 8] = (i == 1 || i == 2) ? d & 8'h0f : d;
      `CHK("cfg", exp_all, cfg_all)
    end
    $display("test config writes done");
    for (i = 0; i < 12; i++) wr(ba[i], $urandom);
    `CHK("cfg", exp_all, cfg_all)
    rd(8'h20, 8'h55);
    rd(8'h28, 8'h33);
    rd(8'h01, `MRB_UNDEF_DATA);
    rd(8'h0b, `MRB_UNDEF_DATA);
    rd(8'h21, `MRB_UNDEF_DATA);
    rd(8'h80, `MRB_UNDEF_DATA);
    $display("test protected places done");
    refresh_rate_pin = 3'h5;
    repeat (4) @(negedge sys_clk);
    rd(8'h04, 8'h85);
    rd(8'h04, 8'h05);
    repeat (6) @(negedge sys_clk);
    `CHK("reads left", 0, exp_q.size())
    $display("test refresh status done");
    rst_b = 1'b0;
    @(negedge sys_clk);
    `CHK("cfg", {8'h22, 48'h0}, cfg_all)
    `CHK("busy", 1'b1, auto_init_busy_q)
    rst_b = 1'b1;
    $display("test second reset done");
    print_verdict;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
